// >>> hdl/dmaev_consts.svh
/*
  Constants for the DMA event set and masked status block: register offsets,
  event bit positions, reset values.
  Assumes inclusion by bare name from the package and the design module.
*/
// Notes on behaviour
// - a one written to a bit of the force register sets that event and its raw status bit.
// - a forced event that is enabled shows in the masked view just like a hardware event.
// - software may force any event regardless of transfer activity.
// - a completion bit of the masked view reads 1 when the event occurred and is enabled, else 0.
// - channel n completion is raised when its size counter reaches zero, on bit n, bits 15..0.
// - early warning for channels 0..7 is raised at the threshold, on bit 16+n.
// - the source address fault sits on bit 24.
// - the source data fault sits on bit 25.
// - bits 31..26 of the force register are reserved, writes do nothing, all fields reset to zero.
// - the number of completion channels is a build parameter; absent channels have no effect.
// - each masked bit is the AND of its enable bit and its raw bit.
// - writing zero to a force bit leaves the raw status unchanged.
// - writing a one to a bit of the clear register clears the raw bit, unless an event or a force sets it in the same cycle.
`ifndef DMAEV_CONSTS_SVH
`define DMAEV_CONSTS_SVH
`define DMAEV_OFS_RAW      13'h1060
`define DMAEV_OFS_ENABLE   13'h1058
`define DMAEV_OFS_VIEW     13'h1068
`define DMAEV_OFS_FORCE    13'h1070
`define DMAEV_OFS_CLEAR    13'h1078
`define DMAEV_ADDR_W       13
`define DMAEV_DONE_LSB     0
`define DMAEV_EARLY_LSB    16
`define DMAEV_EARLY_N      8
`define DMAEV_ADDR_BIT     24
`define DMAEV_DATA_BIT     25
`define DMAEV_USED_W       26
`define DMAEV_MAX_CHAN     16
`define DMAEV_RESET_VAL    32'h0000_0000
`define DMAEV_ZERO_BIT     1'b0
`endif

// >>> hdl/dmaev_pkg.sv
/*
  Types for the DMA event block: the hardware event bundle.
  Assumes dmaev_consts.svh sits on the include path.
*/
`include "dmaev_consts.svh"
package dmaev_pkg;
  typedef struct packed {
    logic [`DMAEV_MAX_CHAN-1:0] transfer_done;
    logic [`DMAEV_EARLY_N-1:0]  early_warning;
    logic                       source_address_fault;
    logic                       source_data_fault;
  } dmaev_hw_event_type;
endpackage

// >>> hdl/dmaev_event_unit.sv
/*
  DMA event status unit: raw event status, enable mask, masked view,
  software force and clear, APB slave and one level interrupt.
  Assumes hardware event inputs are one-cycle pulses synchronous to pclk and
  that the transfer engine raises them (size counter zero, threshold reached).
*/
`timescale 1ns/10ps
`default_nettype none
`include "dmaev_consts.svh"
module dmaev_event_unit #(
  parameter int CHANNELS = 16
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // hardware events
  input  wire dmaev_pkg::dmaev_hw_event_type hw_event,
  // interrupt
  output logic                           irq
);

  typedef logic [`DMAEV_USED_W-1:0] dmaev_vec_type;

  // bits that exist in this build: absent channels and reserved bits drop out
  function automatic dmaev_vec_type implemented_bits();
    dmaev_vec_type m;
    m = '0;
    for (int i = 0; i < `DMAEV_USED_W; i++) begin
      if (i >= `DMAEV_MAX_CHAN || i < CHANNELS) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [`DMAEV_ADDR_W-1:0] ofs);
    return a[`DMAEV_ADDR_W-1:0] == ofs && a[31:`DMAEV_ADDR_W] == '0;
  endfunction

  localparam dmaev_vec_type IMPL = implemented_bits();

  dmaev_vec_type raw_event_reg, raw_event_next;
  dmaev_vec_type event_enable_reg, event_enable_next;
  dmaev_vec_type enabled_event_view_reg, enabled_event_view_next;
  dmaev_vec_type hw_vec, force_vec, clear_vec;
  logic [31:0]   prdata_reg, prdata_next;
  logic          pready_reg, pready_next;
  logic          pslverr_reg, pslverr_next;
  logic          irq_reg, irq_next;
  logic          wr_acc, rd_acc, mapped;

  assign hw_vec = {hw_event.source_data_fault, hw_event.source_address_fault,
                   hw_event.early_warning, hw_event.transfer_done};

  always_comb begin
    wr_acc    = psel && penable && pwrite && !pready_reg;
    rd_acc    = psel && penable && !pwrite && !pready_reg;
    mapped    = hit(paddr, `DMAEV_OFS_RAW) || hit(paddr, `DMAEV_OFS_ENABLE) ||
                hit(paddr, `DMAEV_OFS_VIEW) || hit(paddr, `DMAEV_OFS_FORCE) ||
                hit(paddr, `DMAEV_OFS_CLEAR);
    // writes with a zero strobe lane leave those bits alone
    force_vec = '0;
    clear_vec = '0;
    if (wr_acc && hit(paddr, `DMAEV_OFS_FORCE)) begin
      force_vec = dmaev_vec_type'(pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}},
                                            {8{pstrb[1]}}, {8{pstrb[0]}}});
    end
    if (wr_acc && hit(paddr, `DMAEV_OFS_CLEAR)) begin
      clear_vec = dmaev_vec_type'(pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}},
                                            {8{pstrb[1]}}, {8{pstrb[0]}}});
    end
  end

  // event status group
  always_comb begin
    // set beats clear so an event landing in the clear cycle is kept
    raw_event_next = ((raw_event_reg & ~clear_vec) | hw_vec | force_vec) & IMPL;
    event_enable_next = event_enable_reg;
    if (wr_acc && hit(paddr, `DMAEV_OFS_ENABLE)) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          for (int i = 0; i < 8; i++) begin
            if (b * 8 + i < `DMAEV_USED_W) begin
              event_enable_next[b * 8 + i] = pwdata[b * 8 + i] & IMPL[b * 8 + i];
            end
          end
        end
      end
    end
    enabled_event_view_next = raw_event_next & event_enable_next;
    irq_next = |enabled_event_view_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_event_reg          <= dmaev_vec_type'(`DMAEV_RESET_VAL);
      event_enable_reg       <= dmaev_vec_type'(`DMAEV_RESET_VAL);
      enabled_event_view_reg <= dmaev_vec_type'(`DMAEV_RESET_VAL);
      irq_reg                <= `DMAEV_ZERO_BIT;
    end else begin
      raw_event_reg          <= raw_event_next;
      event_enable_reg       <= event_enable_next;
      enabled_event_view_reg <= enabled_event_view_next;
      irq_reg                <= irq_next;
    end
  end

  // bus answer group: one wait state, data from registers
  always_comb begin
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = (wr_acc || rd_acc) && !mapped;
    prdata_next  = `DMAEV_RESET_VAL;
    if (rd_acc) begin
      case (paddr[`DMAEV_ADDR_W-1:0])
        `DMAEV_OFS_RAW:    prdata_next = 32'(raw_event_reg);
        `DMAEV_OFS_ENABLE: prdata_next = 32'(event_enable_reg);
        `DMAEV_OFS_VIEW:   prdata_next = 32'(enabled_event_view_reg);
        default:           prdata_next = `DMAEV_RESET_VAL;
      endcase
      if (!mapped) begin
        prdata_next = `DMAEV_RESET_VAL;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= `DMAEV_RESET_VAL;
      pready_reg  <= `DMAEV_ZERO_BIT;
      pslverr_reg <= `DMAEV_ZERO_BIT;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  // checks
  sequence s_force_write(int bit_i);
    wr_acc && hit(paddr, `DMAEV_OFS_FORCE) && pwdata[bit_i] && pstrb[bit_i / 8];
  endsequence

  property p_force_sets_raw;
    @(posedge pclk) disable iff (!presetn)
      s_force_write(0) |=> raw_event_reg[0];
  endproperty
  a_force_sets_raw: assert property (p_force_sets_raw) else $error("force did not set raw bit 0");

  property p_force_shows_view;
    @(posedge pclk) disable iff (!presetn)
      (s_force_write(24) ##0 event_enable_next[24]) |=> enabled_event_view_reg[24];
  endproperty
  a_force_shows_view: assert property (p_force_shows_view) else $error("forced event not in view");

  property p_view_is_and;
    @(posedge pclk) disable iff (!presetn)
      enabled_event_view_reg == (raw_event_reg & event_enable_reg);
  endproperty
  a_view_is_and: assert property (p_view_is_and) else $error("view is not raw and enable");

  property p_done_raises;
    @(posedge pclk) disable iff (!presetn)
      hw_event.transfer_done[0] |=> raw_event_reg[0];
  endproperty
  a_done_raises: assert property (p_done_raises) else $error("completion event lost");

  property p_early_raises;
    @(posedge pclk) disable iff (!presetn)
      hw_event.early_warning[7] |=> raw_event_reg[23];
  endproperty
  a_early_raises: assert property (p_early_raises) else $error("early warning not on bit 23");

  property p_faults_raise;
    @(posedge pclk) disable iff (!presetn)
      (hw_event.source_address_fault && hw_event.source_data_fault)
        |=> raw_event_reg[24] && raw_event_reg[25];
  endproperty
  a_faults_raise: assert property (p_faults_raise) else $error("fault bits not set");

  property p_zero_write_no_change;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(paddr, `DMAEV_OFS_FORCE) && pwdata == '0 && hw_vec == '0)
        |=> raw_event_reg == $past(raw_event_reg);
  endproperty
  a_zero_write_no_change: assert property (p_zero_write_no_change) else $error("zero write changed raw");

  property p_clear_works;
    @(posedge pclk) disable iff (!presetn)
      (clear_vec[3] && !hw_vec[3] && !force_vec[3]) |=> !raw_event_reg[3];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("clear did not clear bit 3");

  property p_set_beats_clear;
    @(posedge pclk) disable iff (!presetn)
      (hw_vec[1] && clear_vec[1]) |=> raw_event_reg[1];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost to clear");

  property p_absent_quiet;
    @(posedge pclk) disable iff (!presetn)
      (raw_event_reg & ~IMPL) == '0;
  endproperty
  a_absent_quiet: assert property (p_absent_quiet) else $error("absent channel bit set");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      irq == (|enabled_event_view_reg);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq does not match view");

  // an access phase that the slave has not yet answered
  sequence s_access;
    psel && penable && !pready_reg;
  endsequence

  property p_ready_after_access;
    @(posedge pclk) disable iff (!presetn)
      s_access |=> pready;
  endproperty
  a_ready_after_access: assert property (p_ready_after_access) else $error("no ready after access");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

  property p_force_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (s_access ##0 (!pwrite && hit(paddr, `DMAEV_OFS_FORCE))) |=> prdata == '0;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force read not zero");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      prdata[31:`DMAEV_USED_W] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read set");

  property p_unmapped_no_effect;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && !mapped && hw_vec == '0)
        |=> raw_event_reg == $past(raw_event_reg) && event_enable_reg == $past(event_enable_reg);
  endproperty
  a_unmapped_no_effect: assert property (p_unmapped_no_effect) else $error("unmapped write acted");

  property p_enable_absent;
    @(posedge pclk) disable iff (!presetn)
      (event_enable_reg & ~IMPL) == '0;
  endproperty
  a_enable_absent: assert property (p_enable_absent) else $error("absent enable bit set");

  property p_force_any;
    @(posedge pclk) disable iff (!presetn)
      s_force_write(25) |=> raw_event_reg[25];
  endproperty
  a_force_any: assert property (p_force_any) else $error("force of bit 25 lost");

  property p_force_early;
    @(posedge pclk) disable iff (!presetn)
      s_force_write(16) |=> raw_event_reg[16];
  endproperty
  a_force_early: assert property (p_force_early) else $error("force of bit 16 lost");

  property p_hw_shows_view;
    @(posedge pclk) disable iff (!presetn)
      (hw_event.transfer_done[2] && event_enable_next[2]) |=> enabled_event_view_reg[2] && irq;
  endproperty
  a_hw_shows_view: assert property (p_hw_shows_view) else $error("hardware event not in view");

  property p_view_masked_out;
    @(posedge pclk) disable iff (!presetn)
      !event_enable_reg[5] |-> !enabled_event_view_reg[5];
  endproperty
  a_view_masked_out: assert property (p_view_masked_out) else $error("masked bit shows in view");

  property p_raw_sticky;
    @(posedge pclk) disable iff (!presetn)
      (raw_event_reg[0] && !clear_vec[0]) |=> raw_event_reg[0];
  endproperty
  a_raw_sticky: assert property (p_raw_sticky) else $error("raw bit 0 dropped");

endmodule
`default_nettype wire

// >>> test/testbench.sv
/*
  Self-checking bench for the DMA event unit: APB tasks reach force, clear,
  enable and view registers while hardware event pulses are driven.
  Assumes dmaev_consts.svh on the include path and dmaev_pkg compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dmaev_consts.svh"
module testbench;
  // twelve channels so that absent completion bits get exercised
  localparam int          CHANNELS   = 12;
  localparam logic [31:0] IMPL       = 32'h03FF_0FFF;
  localparam int          MAX_CYCLES = 20000;
  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [31:0]                   paddr;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic [3:0]                    pstrb;
  logic                          pready;
  logic                          pslverr;
  logic                          irq;
  dmaev_pkg::dmaev_hw_event_type hw_event;
  dmaev_pkg::dmaev_hw_event_type ev;
  logic [31:0]                   rd;
  logic [31:0]                   exp;
  logic                          err;
  int                            n_fail = 0;
  int                            tests_run = 0;
  int                            cycles = 0;

  dmaev_event_unit #(.CHANNELS(CHANNELS)) dmaev_event_unit_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_event(hw_event), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, e, got);
    end
  endtask

  // entered just after a rising edge; the request is held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [`DMAEV_ADDR_W-1:0] o, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= 32'(o);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input dmaev_pkg::dmaev_hw_event_type e);
    hw_event <= e;
    @(posedge pclk);
    hw_event <= '0;
    @(posedge pclk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0000_0000; pwdata = 32'h0000_0000; pstrb = 4'hF; hw_event = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DMAEV_OFS_RAW, 32'h0); check("raw reset", 32'h0, rd);
    apb(1'b0, `DMAEV_OFS_FORCE, 32'h0); check("force reset", 32'h0, rd);
    $display("test reset done");
    apb(1'b1, `DMAEV_OFS_FORCE, 32'hFFFF_FFFF);
    apb(1'b0, `DMAEV_OFS_RAW, 32'h0); check("raw forced", IMPL, rd);
    apb(1'b0, `DMAEV_OFS_VIEW, 32'h0); check("view masked", 32'h0, rd);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `DMAEV_OFS_ENABLE, 32'hFFFF_FFFF);
    apb(1'b0, `DMAEV_OFS_VIEW, 32'h0); check("view enabled", IMPL, rd);
    check("irq enabled", 32'h1, {31'h0, irq});
    apb(1'b1, `DMAEV_OFS_CLEAR, 32'hFFFF_FFFF);
    apb(1'b0, `DMAEV_OFS_RAW, 32'h0); check("raw cleared", 32'h0, rd);
    check("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, `DMAEV_OFS_FORCE, 32'h20);
    apb(1'b1, `DMAEV_OFS_FORCE, 32'h0);
    apb(1'b0, `DMAEV_OFS_RAW, 32'h0); check("force zero", 32'h20, rd);
    apb(1'b1, `DMAEV_OFS_CLEAR, 32'hFFFF_FFFF);
    $display("test force done");
    for (int k = 0; k < 26; k++) begin
      ev = '0;
      if (k < 16) ev.transfer_done[k] = 1'b1;
      else if (k < 24) ev.early_warning[k-16] = 1'b1;
      else if (k == 24) ev.source_address_fault = 1'b1;
      else ev.source_data_fault = 1'b1;
      exp = (k >= CHANNELS && k < 16) ? 32'h0 : (32'h1 << k);
      pulse(ev);
      apb(1'b0, `DMAEV_OFS_RAW, 32'h0); check("raw per event", exp, rd);
      apb(1'b1, `DMAEV_OFS_CLEAR, 32'hFFFF_FFFF);
    end
    $display("test event map done");
    apb(1'b1, `DMAEV_OFS_ENABLE, 32'h8);
    ev = '0;
    ev.transfer_done[3] = 1'b1;
    ev.transfer_done[4] = 1'b1;
    pulse(ev);
    apb(1'b0, `DMAEV_OFS_VIEW, 32'h0); check("view partial", 32'h8, rd);
    check("irq partial", 32'h1, {31'h0, irq});
    apb(1'b1, `DMAEV_OFS_CLEAR, 32'h8);
    check("irq after clear", 32'h0, {31'h0, irq});
    apb(1'b0, `DMAEV_OFS_RAW, 32'h0); check("raw after clear", 32'h10, rd);
    $display("test mask done");
    // hardware level held across a force and a clear of the same bit
    ev = '0;
    ev.transfer_done[7] = 1'b1;
    hw_event <= ev;
    apb(1'b1, `DMAEV_OFS_FORCE, 32'h80);
    apb(1'b1, `DMAEV_OFS_CLEAR, 32'h80);
    hw_event <= '0;
    @(posedge pclk);
    apb(1'b0, `DMAEV_OFS_RAW, 32'h0); check("raw collision", 32'h90, rd);
    apb(1'b0, 13'h1064, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    $display("test collision and unmapped done");
    wrap_up();
  end
endmodule
`default_nettype wire
